// file: src/ars_pkg.sv
/*
 * constants for the converter reference select and temperature offset
 * register block: page/address decode, field positions, reset values.
 * assumes an 8051-style special-function register bus with page select.
 */
package ars_pkg;
	localparam logic [3:0] PAGE_CTRL = 4'h0;
	localparam logic [3:0] PAGE_OFFSET = 4'hf;
	localparam logic [7:0] ADDR_REFERENCE_CONTROL = 8'hd1;
	localparam logic [7:0] ADDR_TEMP_OFFSET_LOW = 8'h85;
	localparam logic [7:0] ADDR_TEMP_OFFSET_HIGH = 8'h86;
	localparam logic [7:0] REFERENCE_CONTROL_RESET = 8'h18;
	localparam logic [7:0] REFERENCE_CONTROL_WMASK = 8'h3d;
	localparam int BIT_ANALOG_GROUND_SELECT = 5;
	localparam int BIT_REF_SELECT_HI = 4;
	localparam int BIT_REF_SELECT_LO = 3;
	localparam int BIT_TEMP_SENSOR_ENABLE = 2;
	localparam int BIT_PRECISION_REF_OE = 0;
	localparam int OFFSET_WIDTH = 10;
	localparam logic [9:0] TEMP_OFFSET_DEFAULT = 10'h000;

	typedef enum logic [1:0] {
		ARS_REF_EXT_PIN = 2'h0,
		ARS_REF_SUPPLY = 2'h1,
		ARS_REF_DIGITAL = 2'h2,
		ARS_REF_HIGH_SPEED = 2'h3
	} ars_ref_e;
endpackage

// file: src/ars_offset_store.sv
/*
 * read-only store for the factory temperature offset word.
 * assumes the trim value arrives on a static input from fuse logic;
 * it is captured one clock after reset release and then held.
 */
`timescale 1ns/10ps
module ars_offset_store (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [9:0] trim_value,
	output logic [9:0] offset_value
);
	typedef struct packed {
		logic loaded;
		logic [9:0] value;
	} ars_store_s;

	ars_store_s state_reg;
	ars_store_s state_next;

	// capture once after reset; processor writes never reach this store
	always_comb begin
		state_next = state_reg;
		if (!state_reg.loaded) begin
			state_next.loaded = 1'b1;
			state_next.value = trim_value;
		end
	end

	// async reset loads constants only; trim is caught on a clock edge
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= '{loaded: 1'b0,
				value: ars_pkg::TEMP_OFFSET_DEFAULT};
		end else begin
			state_reg <= state_next;
		end
	end

	assign offset_value = state_reg.value;
endmodule

// file: src/ars_reference_regs.sv
/*
 * reference control and temperature offset registers of the converter.
 * holds the reference control register and two read-only offset bytes,
 * drives the reference and ground multiplexer selects.
 * assumes a synchronous special-function bus on mclk with page select,
 * and converter status signals from logic on the same clock.
 */
// What this block does
// - offset bits 9:2 read as high byte
// - offset bits 1:0 in low byte 7:6
// - offset bytes at 0x86/0x85 on page 0xF
// - control register at 0xD1 on page 0x0
// - bit 5 selects analog ground pin
// - bits 4:3 select voltage reference source
// - high-speed reference enabled only when converter busy
// - bit 2 enables temperature sensor
// - bit 0 enables precision reference onto pin
// - unused control bits read zero, ignore writes
// - ground select applies in tracking and conversion
// - temperature sensor sampling forces chip ground
// - high-speed reference forces chip ground in conversion
// - offset holds factory sensor measurement result
`timescale 1ns/10ps
module ars_reference_regs (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [3:0] sfr_page,
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	input wire logic [9:0] trim_value,
	input wire logic converter_active,
	input wire logic converter_tracking,
	input wire logic converter_converting,
	input wire logic temp_sensor_channel,
	output logic [1:0] reference_select,
	output logic high_speed_ref_enable,
	output logic precision_ref_output_enable,
	output logic temp_sensor_enable,
	output logic use_analog_ground_pin,
	output logic [9:0] temp_offset_value
);
	typedef struct packed {
		logic [7:0] ctrl;
		logic [7:0] rdata;
		logic hs_enable;
		logic analog_ground_pin_use;
	} ars_regs_s;

	ars_regs_s state_reg;
	ars_regs_s state_next;
	logic [9:0] offset_word;
	logic sel_ctrl;
	logic sel_low;
	logic sel_high;
	logic hs_selected;
	logic analog_ground_pin_wanted;

	// offset word is fixed after reset; kept apart so no bus path exists
	ars_offset_store u_offset (
		.mclk(mclk),
		.rst_b(rst_b),
		.trim_value(trim_value),
		.offset_value(offset_word)
	);

	// page qualified address decode
	assign sel_ctrl = (sfr_page == ars_pkg::PAGE_CTRL) &&
		(sfr_addr == ars_pkg::ADDR_REFERENCE_CONTROL);
	assign sel_low = (sfr_page == ars_pkg::PAGE_OFFSET) &&
		(sfr_addr == ars_pkg::ADDR_TEMP_OFFSET_LOW);
	assign sel_high = (sfr_page == ars_pkg::PAGE_OFFSET) &&
		(sfr_addr == ars_pkg::ADDR_TEMP_OFFSET_HIGH);
	assign sfr_hit = sel_ctrl || sel_low || sel_high;

	assign hs_selected = state_reg.ctrl[ars_pkg::BIT_REF_SELECT_HI:
		ars_pkg::BIT_REF_SELECT_LO] == ars_pkg::ARS_REF_HIGH_SPEED;

	// ground mux: pin only if no internal-ground override applies
	always_comb begin
		analog_ground_pin_wanted = state_reg.ctrl[ars_pkg::BIT_ANALOG_GROUND_SELECT];
		if (!(converter_tracking || converter_converting)) begin
			analog_ground_pin_wanted = analog_ground_pin_wanted;
		end
		if (converter_tracking && temp_sensor_channel) begin
			analog_ground_pin_wanted = 1'b0;
		end
		if (converter_converting && hs_selected) begin
			analog_ground_pin_wanted = 1'b0;
		end
	end

	// register updates and registered read data
	always_comb begin
		state_next = state_reg;
		if (sfr_wr && sel_ctrl) begin
			// unused bits masked so they stay zero
			state_next.ctrl = sfr_wdata &
				ars_pkg::REFERENCE_CONTROL_WMASK;
		end
		// writes to offset bytes have no target at all
		if (sfr_wr && (sel_low || sel_high)) begin
			state_next.ctrl = state_reg.ctrl;
		end
		state_next.rdata = 8'h00;
		if (sfr_rd && sel_ctrl) begin
			state_next.rdata = state_reg.ctrl;
		end else if (sfr_rd && sel_high) begin
			state_next.rdata = offset_word[9:2];
		end else if (sfr_rd && sel_low) begin
			state_next.rdata = {offset_word[1:0], 6'h00};
		end
		// on-demand high-speed reference, no software step
		state_next.hs_enable = hs_selected && converter_active;
		state_next.analog_ground_pin_use = analog_ground_pin_wanted;
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_reg <= '{ctrl: ars_pkg::REFERENCE_CONTROL_RESET,
				rdata: 8'h00, hs_enable: 1'b0, analog_ground_pin_use: 1'b0};
		end else begin
			state_reg <= state_next;
		end
	end

	// analog control outputs from the register fields and the registered high-speed and ground state
	assign reference_select = state_reg.ctrl[ars_pkg::BIT_REF_SELECT_HI:
		ars_pkg::BIT_REF_SELECT_LO];
	assign temp_sensor_enable =
		state_reg.ctrl[ars_pkg::BIT_TEMP_SENSOR_ENABLE];
	assign precision_ref_output_enable =
		state_reg.ctrl[ars_pkg::BIT_PRECISION_REF_OE];
	assign high_speed_ref_enable = state_reg.hs_enable;
	assign use_analog_ground_pin = state_reg.analog_ground_pin_use;
	assign sfr_rdata = state_reg.rdata;
	assign temp_offset_value = offset_word;
endmodule

// file: verif/ars_reference_regs_properties.sv
/* port assertions for ars_reference_regs; bound by name at the foot */
`timescale 1ns/10ps
module ars_props (
	input wire logic mclk, rst_b, sfr_wr, sfr_rd, sfr_hit, converter_active,
		converter_tracking, converter_converting, temp_sensor_channel,
		high_speed_ref_enable, use_analog_ground_pin,
	input wire logic [3:0] sfr_page,
	input wire logic [7:0] sfr_addr, sfr_wdata, sfr_rdata,
	input wire logic [1:0] reference_select,
	input wire logic [9:0] temp_offset_value
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// decodes carry the page, so mirrors on other pages stay dead
	wire ctl = sfr_page == 4'h0 && sfr_addr == 8'hd1;
	wire lo = sfr_page == 4'hf && sfr_addr == 8'h85;
	wire hi = sfr_page == 4'hf && sfr_addr == 8'h86;
	wire hs_want = reference_select == 2'h3 && converter_active;
	a_hit_decode: assert property (
		sfr_hit == (ctl || lo || hi)) else $error("bad hit");
	a_sel_write: assert property (
		sfr_wr && ctl |=> reference_select == $past(sfr_wdata[4:3]))
		else $error("bad select");
	a_hs_follow: assert property (
		1 |=> high_speed_ref_enable == $past(hs_want)) else $error("bad hs");
	a_sensor_gnd: assert property (
		converter_tracking && temp_sensor_channel |=> !use_analog_ground_pin)
		else $error("sensor on ground pin");
	a_hs_gnd: assert property (
		converter_converting && reference_select == 2'h3
		|=> !use_analog_ground_pin) else $error("hs on ground pin");
	a_miss_read: assert property (
		sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00) else $error("stray data");
	a_high_read: assert property (
		sfr_rd && hi |=> sfr_rdata == temp_offset_value[9:2])
		else $error("bad high byte");
	a_low_read: assert property (
		sfr_rd && lo |=> sfr_rdata == {temp_offset_value[1:0], 6'h00})
		else $error("bad low byte");
	// main scenarios reached
	c_hs_on: cover property (high_speed_ref_enable);
	c_analog_ground_pin: cover property (use_analog_ground_pin);
	c_off_rd: cover property (sfr_rd && hi);
endmodule
bind ars_reference_regs ars_props u_props (.*);

// file: verif/ars_reference_regs_tb.sv
/* self-checking bench for ars_reference_regs; the checker binds itself */
`timescale 1ns/10ps
module ars_reference_regs_tb;
	logic mclk = 0, rst_b = 0, sfr_wr = 0, sfr_rd = 0, rd_d = 0, sfr_hit;
	logic converter_active = 0, converter_tracking = 0, temp_sensor_enable;
	logic converter_converting = 0, temp_sensor_channel = 0;
	logic high_speed_ref_enable, precision_ref_output_enable;
	logic use_analog_ground_pin;
	logic [1:0] reference_select;
	logic [3:0] sfr_page = 0;
	logic [7:0] sfr_addr = 0, sfr_wdata = 0, sfr_rdata, d, q[$];
	logic [9:0] trim_value, temp_offset_value;
	int errors = 0, checks = 0, seed = 5166, cyc = 0;
	ars_reference_regs uut (.*);
	// 50 MHz clock
	initial forever #10 mclk = ~mclk;
	// case equality, so an unknown never matches
	task automatic chk(input string n, input logic [9:0] e, g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	// one strobe cycle, driven at the falling edge; reads note a result
	task automatic acc(logic [3:0] p, logic [7:0] a, w, bit r, logic [7:0] e);
		@(negedge mclk);
		if (r)
			q.push_back(e);
		{sfr_page, sfr_addr, sfr_wdata, sfr_rd, sfr_wr} = {p, a, w, r, !r};
		@(negedge mclk);
		{sfr_rd, sfr_wr} = 2'h0;
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// read data answers one edge after its strobe; a hang is cut short
	always @(posedge mclk) begin
		if (rd_d)
			chk("rdata", q.pop_front(), sfr_rdata);
		rd_d <= sfr_rd;
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			errors++;
			summarize();
		end
	end
	// offset writes first, then reads: the stored word must not move
	initial begin
		trim_value = 10'($random(seed));
		repeat (5) @(negedge mclk);
		rst_b = 1;
		acc(4'h0, 8'hd1, 8'h00, 1, 8'h18);
		for (int i = 0; i < 2; i++) begin
			acc(4'hf, 8'h86, 8'hff, i[0], trim_value[9:2]);
			acc(4'hf, 8'h85, 8'hff, i[0], {trim_value[1:0], 6'h00});
		end
		acc(4'h0, 8'h85, 8'h00, 1, 8'h00);
		acc(4'hf, 8'hd1, 8'h00, 1, 8'h00);
		chk("hit", 1'h0, sfr_hit);
		for (int i = 0; i < 4; i++) begin
			d = {2'($random(seed)), 1'h1, i[1:0], 3'($random(seed))};
			acc(4'h0, 8'hd1, d, 0, 8'h00);
			acc(4'h0, 8'hd1, 8'h00, 1, d & 8'h3d);
			chk("ctl", {d[4:2], d[0], 1'h1}, {reference_select,
				temp_sensor_enable, precision_ref_output_enable,
				use_analog_ground_pin});
		end
		{converter_active, converter_converting} = 2'h3;
		repeat (2) @(negedge mclk);
		chk("hs", 2'h2, {high_speed_ref_enable, use_analog_ground_pin});
		{converter_active, converter_converting} = 2'h0;
		{converter_tracking, temp_sensor_channel} = 2'h3;
		repeat (2) @(negedge mclk);
		chk("hs", 2'h0, {high_speed_ref_enable, use_analog_ground_pin});
		// precision reference raised in the same write that selects the external pin reference
		acc(4'h0, 8'hd1, 8'h01, 0, 8'h00);
		acc(4'h0, 8'hd1, 8'h01, 1, 8'h01);
		chk("ref", 3'h1, {reference_select,
			precision_ref_output_enable});
		// external reference with the analog ground pin in tracking
		acc(4'h0, 8'hd1, 8'h20, 0, 8'h00);
		temp_sensor_channel = 0;
		repeat (2) @(negedge mclk);
		chk("gnd", 4'h1, {reference_select,
			precision_ref_output_enable, use_analog_ground_pin});
		chk("hit", 1'h1, sfr_hit);
		chk("offset", trim_value, temp_offset_value);
		@(negedge mclk);
		summarize();
	end
endmodule
